// *** regulator_control.sv ***
// Regulator control and status register with memory power gating control.
// Assumes a single-cycle SFR bus on mclk_i; the analog regulators sit outside.
//
// How it works
// - Bit 7 at 1 disables the bus-side regulator; at 0 it stays enabled.
// - Read-only bit 6 reports the present synchronised bus supply level.
// - Bit 4 at 1 puts the bus-side regulator into low-power suspend mode.
// - Bit 3 at 0 keeps the core regulator on during stop mode.
// - Bit 3 at 1 shuts the core regulator in stop; only pin reset works.
// - Bit 1 at 1 runs the core regulator in low-power mode.
// - Bit 0 at 1 gates program memory power whenever no fetch is active.
// - Prefetch enabled overrides bit 0; program memory stays powered.
// - After a slow-to-fast clock change with gating on, 20 clocks stall memory reads.
// - Each edge of the bus supply pulses the supply interrupt when enabled.
`timescale 1ns/1ps
module regulator_control
  import regctl_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  input  wire sfr_req_s   sfr_req_i,
  input  wire logic       bus_supply_pin_i,
  input  wire logic       supply_irq_enable_i,
  input  wire logic       stop_mode_i,
  input  wire logic       prefetch_enable_i,
  input  wire logic       fetch_active_i,
  input  wire logic       clock_speed_up_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            sfr_sel_o,
  output power_ctl_s      power_ctl_o,
  output logic            ext_reset_only_o,
  output logic            mem_power_on_o,
  output logic            mem_read_stall_o,
  output logic            supply_irq_o
);

  // ---------------------------------------------------------------
  // Bus supply pin synchronisation
  // ---------------------------------------------------------------
  logic supply_level;
  logic supply_edge;

  bus_supply_sync u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .pin_i     (bus_supply_pin_i),
    .level_o   (supply_level),
    .edge_o    (supply_edge)
  );

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] ctl_q;
  logic       hit;

  function automatic logic addr_hit(input logic [7:0] a);
    return a == REGULATOR_CONTROL_ADDR;
  endfunction

  assign hit = addr_hit(sfr_req_i.addr);

  // Reserved and status positions never store, so a careless write cannot set them.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_q <= REGULATOR_CONTROL_RST;
    end else if (ce_i && sfr_req_i.wr && hit) begin
      ctl_q <= sfr_req_i.wdata & WRITE_MASK;
    end
  end

  // Read data is registered; the status bit shows the live supply level.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_sel_o   <= 1'b0;
    end else if (ce_i) begin
      sfr_sel_o <= sfr_req_i.rd && hit;
      if (sfr_req_i.rd && hit) begin
        sfr_rdata_o <= ctl_q | ({7'h00, supply_level} << BIT_BUS_SUPPLY_PRESENT);
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Regulator controls
  // ---------------------------------------------------------------
  // Outputs are registered to keep glitches off the analog controls.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_ctl_o      <= POWER_CTL_RST;
      ext_reset_only_o <= 1'b0;
    end else if (ce_i) begin
      power_ctl_o.bus_regulator_enable    <= ~ctl_q[BIT_BUS_REG_DISABLE];
      power_ctl_o.bus_regulator_low_power <= ctl_q[BIT_BUS_REG_LOW_POWER];
      // Core regulator stays on in stop unless the stop bit asks to shut it.
      power_ctl_o.core_regulator_on_in_stop <= ~ctl_q[BIT_STOP_CORE_OFF];
      // Low-power core mode is passed as written; software keeps the pairing.
      power_ctl_o.core_regulator_low_power <= ctl_q[BIT_CORE_REG_LOW_POWER];
      power_ctl_o.memory_power_gate <= ctl_q[BIT_MEM_GATE_ENABLE] & ~prefetch_enable_i;
      // With the core off in stop, only the reset pin or power cycle restarts.
      ext_reset_only_o <= stop_mode_i & ctl_q[BIT_STOP_CORE_OFF];
    end
  end

  // ---------------------------------------------------------------
  // Supply change interrupt
  // ---------------------------------------------------------------
  // Edge pulse only; there is no pending flag to clear.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      supply_irq_o <= 1'b0;
    end else if (ce_i) begin
      supply_irq_o <= supply_edge & supply_irq_enable_i;
    end
  end

  // ---------------------------------------------------------------
  // Program memory power gating
  // ---------------------------------------------------------------
  mem_state_e mem_state_q;
  logic [4:0] settle_q;
  logic       gate_on;

  assign gate_on = ctl_q[BIT_MEM_GATE_ENABLE] & ~prefetch_enable_i;

  // A fast clock may outrun the memory's power-up, so reads wait a fixed settle time.
  // The power and stall outputs are set alongside each state change, so they come
  // straight from flops and track the state with no extra cycle of delay.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_state_q      <= MEM_ON;
      settle_q         <= 5'h00;
      mem_power_on_o   <= 1'b1;
      mem_read_stall_o <= 1'b0;
    end else if (ce_i) begin
      case (mem_state_q)
        MEM_ON: begin
          if (gate_on && clock_speed_up_i) begin
            mem_state_q      <= MEM_SETTLE;
            settle_q         <= SETTLE_LOAD;
            mem_read_stall_o <= 1'b1;
          end else if (gate_on && !fetch_active_i) begin
            mem_state_q    <= MEM_GATED;
            mem_power_on_o <= 1'b0;
          end
        end
        MEM_GATED: begin
          if (gate_on && clock_speed_up_i) begin
            mem_state_q      <= MEM_SETTLE;
            settle_q         <= SETTLE_LOAD;
            mem_power_on_o   <= 1'b1;
            mem_read_stall_o <= 1'b1;
          end else if (!gate_on || fetch_active_i) begin
            mem_state_q    <= MEM_ON;
            mem_power_on_o <= 1'b1;
          end
        end
        MEM_SETTLE: begin
          if (settle_q == 5'h01) begin
            mem_state_q      <= MEM_ON;
            settle_q         <= 5'h00;
            mem_read_stall_o <= 1'b0;
          end else begin
            settle_q <= settle_q - 5'h01;
          end
        end
        default: begin
          mem_state_q      <= MEM_ON;
          settle_q         <= 5'h00;
          mem_power_on_o   <= 1'b1;
          mem_read_stall_o <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_bus_reg;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i && $past(ce_i) |-> power_ctl_o.bus_regulator_enable == ~$past(ctl_q[7]);
  endproperty
  a_bus_reg: assert property (p_bus_reg) else $error("bus regulator enable mismatch");
  property p_status;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i && sfr_req_i.rd && hit |=> sfr_rdata_o[6] == $past(supply_level);
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong");
  property p_bus_lp;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i |=> power_ctl_o.bus_regulator_low_power == $past(ctl_q[4]);
  endproperty
  a_bus_lp: assert property (p_bus_lp) else $error("bus low power wrong");
  property p_stop_on;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i && !ctl_q[3] |=> power_ctl_o.core_regulator_on_in_stop && !ext_reset_only_o;
  endproperty
  a_stop_on: assert property (p_stop_on) else $error("core off in stop");
  property p_stop_off;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i && ctl_q[3] && stop_mode_i |=> ext_reset_only_o;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("reset limit missing");
  property p_core_lp;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i |=> power_ctl_o.core_regulator_low_power == $past(ctl_q[1]);
  endproperty
  a_core_lp: assert property (p_core_lp) else $error("core low power wrong");
  property p_prefetch;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i && prefetch_enable_i |=> mem_power_on_o;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("gated under prefetch");
  sequence s_settle_start;
    ce_i && gate_on && clock_speed_up_i && mem_state_q != MEM_SETTLE;
  endsequence
  property p_settle;
    @(posedge mclk_i) disable iff (sys_rst_i)
      s_settle_start ##1 ce_i [*8] |-> mem_read_stall_o;
  endproperty
  a_settle: assert property (p_settle) else $error("settle too short");
  property p_irq;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ce_i && supply_edge && supply_irq_enable_i |=> supply_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("supply edge lost");

endmodule // regulator_control

// *** regctl_pkg.sv ***
// Package for the regulator control register block.
// Assumes an 8-bit special function register bus with a byte address.
package regctl_pkg;

  // ---------------------------------------------------------------
  // Register map and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'hC9;
  localparam logic [7:0] REGULATOR_CONTROL_RST  = 8'h00;
  localparam int         BIT_BUS_REG_DISABLE    = 7;
  localparam int         BIT_BUS_SUPPLY_PRESENT = 6;
  localparam int         BIT_RSVD_HI            = 5;
  localparam int         BIT_BUS_REG_LOW_POWER  = 4;
  localparam int         BIT_STOP_CORE_OFF      = 3;
  localparam int         BIT_RSVD_LO            = 2;
  localparam int         BIT_CORE_REG_LOW_POWER = 1;
  localparam int         BIT_MEM_GATE_ENABLE    = 0;
  // Writable bits; the supply status bit and the reserved bits are masked.
  localparam logic [7:0] WRITE_MASK             = 8'h9B;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Clocks skipped after a slow-to-fast clock change with gating on.
  localparam logic [4:0] SETTLE_LOAD            = 5'h14;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic bus_regulator_enable;
    logic bus_regulator_low_power;
    logic core_regulator_on_in_stop;
    logic core_regulator_low_power;
    logic memory_power_gate;
  } power_ctl_s;

  // Reset value of the regulator controls: both regulators on, normal mode, gating off.
  localparam power_ctl_s POWER_CTL_RST = 5'h14;

  typedef enum logic [2:0] {
    MEM_ON     = 3'b001,
    MEM_GATED  = 3'b010,
    MEM_SETTLE = 3'b100
  } mem_state_e;

endpackage : regctl_pkg

// *** bus_supply_sync.sv ***
// Two-stage synchroniser and edge detector for the bus supply pin.
// Assumes the pin is asynchronous to mclk_i.
`timescale 1ns/1ps
module bus_supply_sync (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      edge_o
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // The first stage feeds only the second stage to keep metastability contained.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce_i) begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign edge_o  = sync_q ^ last_q;

endmodule // bus_supply_sync

// *** testbench.sv ***
// Self-checking testbench for the regulator control register block.
// Assumes the design package is compiled first; the bench drives all inputs on falling edges.
`timescale 1ns/1ps
module testbench;
  import regctl_pkg::*;

  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic       mclk_i, sys_rst_i, ce_i, pin, irq_en, stop, pref, fetch, spd;
  sfr_req_s   req;
  logic [7:0] rdata;
  logic       sel, ext_only, mem_on, stall, irq;
  power_ctl_s pc;
  int         num_errors, checked, cyc, n;

  regulator_control dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .sfr_req_i(req),
    .bus_supply_pin_i(pin), .supply_irq_enable_i(irq_en), .stop_mode_i(stop),
    .prefetch_enable_i(pref), .fetch_active_i(fetch), .clock_speed_up_i(spd),
    .sfr_rdata_o(rdata), .sfr_sel_o(sel), .power_ctl_o(pc), .ext_reset_only_o(ext_only),
    .mem_power_on_o(mem_on), .mem_read_stall_o(stall), .supply_irq_o(irq));

  // ----------------------------------------------------------------
  // Clock, reset and hang guard
  // ----------------------------------------------------------------
  // The guard is far above the roughly 120 cycles the sequence needs.
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Access and comparison tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // A write is taken on the rising edge inside the task.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req.wr = 1'b1; req.addr = a; req.wdata = d;
    @(negedge mclk_i);
    req.wr = 1'b0;
  endtask
  // Read data and select are registered, so they are looked at one cycle on.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic es);
    @(negedge mclk_i);
    req.rd = 1'b1; req.addr = a;
    @(negedge mclk_i);
    req.rd = 1'b0;
    chk("sel", {7'h00, es}, {7'h00, sel});
    chk("rdata", e, rdata);
  endtask
  // Power controls follow the register one edge after it.
  task automatic ctl(input logic [4:0] e);
    @(negedge mclk_i);
    chk("power_ctl", {3'h0, e}, {3'h0, pc});
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  // Counts supply pulses over a window after one pin toggle.
  task automatic irq_count(input logic en, input int e);
    irq_en = en; pin = ~pin; n = 0;
    repeat (8) begin
      @(negedge mclk_i);
      if (irq === 1'b1) n++;
    end
    chk("supply_irq", e[7:0], n[7:0]);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0; checked = 0; cyc = 0;
    sys_rst_i = 1'b1; ce_i = 1'b1; req = '0; pin = 1'b0; irq_en = 1'b0;
    stop = 1'b0; pref = 1'b0; fetch = 1'b1; spd = 1'b0;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    rd(REGULATOR_CONTROL_ADDR, 8'h00, 1'b1);
    ctl(5'h14);
    chk("mem_on", 8'h01, {7'h00, mem_on});
    // The status bit shows the pin, not the write.
    pin = 1'b1;
    wr(REGULATOR_CONTROL_ADDR, 8'hD8);
    ctl(5'h08);
    rd(REGULATOR_CONTROL_ADDR, 8'hD8, 1'b1);
    stop = 1'b1;
    wait_n(2);
    chk("ext_reset_only", 8'h01, {7'h00, ext_only});
    stop = 1'b0;
    wait_n(2);
    chk("ext_reset_only", 8'h00, {7'h00, ext_only});
    pin = 1'b0;
    wr(REGULATOR_CONTROL_ADDR, 8'h43);
    ctl(5'h17);
    wait_n(12);
    rd(REGULATOR_CONTROL_ADDR, 8'h03, 1'b1);
    stop = 1'b1;
    wait_n(2);
    chk("ext_reset_only", 8'h00, {7'h00, ext_only});
    stop = 1'b0;
    // With the enable low the block is frozen, so a write must not land.
    ce_i = 1'b0;
    wr(REGULATOR_CONTROL_ADDR, 8'h80);
    ce_i = 1'b1;
    ctl(5'h17);
    // Other addresses neither answer nor change the register.
    wr(8'hC8, 8'h10);
    rd(8'hC8, 8'h00, 1'b0);
    rd(REGULATOR_CONTROL_ADDR, 8'h03, 1'b1);
    // Gating is on: memory powers down while idle, back up on fetch, and stays up under prefetch.
    fetch = 1'b0;
    wait_n(3);
    chk("mem_on", 8'h00, {7'h00, mem_on});
    fetch = 1'b1;
    wait_n(2);
    chk("mem_on", 8'h01, {7'h00, mem_on});
    fetch = 1'b0; pref = 1'b1;
    wait_n(3);
    chk("mem_on", 8'h01, {7'h00, mem_on});
    pref = 1'b0;
    wait_n(3);
    spd = 1'b1;
    @(negedge mclk_i);
    spd = 1'b0; n = 0;
    repeat (30) begin
      if (stall === 1'b1) n++;
      @(negedge mclk_i);
    end
    chk("stall_cycles", SETTLE_LOAD, n[7:0]);
    wr(REGULATOR_CONTROL_ADDR, 8'h00);
    fetch = 1'b0;
    wait_n(3);
    chk("mem_on", 8'h01, {7'h00, mem_on});
    irq_count(1'b1, 1);
    irq_count(1'b1, 1);
    irq_count(1'b0, 0);
    end_sim();
  end

endmodule // testbench
